// *** hdl/async_serial_tx_rx_core.v ***
`timescale 1ns/10ps
`default_nettype none
`include "async_serial_defines.vh"
module async_serial_tx_rx_core #(
    parameter ALT_PRESCALE = 4
) (
    input  wire       mclk,
    input  wire       reset,
    input  wire [2:0] addr,
    input  wire [7:0] wrData,
    input  wire       wrStrobe,
    input  wire       rdStrobe,
    output reg  [7:0] rdData,
    input  wire       serialIn,
    output reg        serialOut,
    output reg        serialOutEnN,
    output reg        txIrq,
    output reg        rxIrq
);
    localparam TX_IDLE  = 1'b0;
    localparam TX_SHIFT = 1'b1;
    localparam KIND_IDLE  = 2'd0;
    localparam KIND_DATA  = 2'd1;
    localparam KIND_BREAK = 2'd2;
    localparam RX_HUNT  = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_BITS  = 2'd2;

    // control
    reg        moduleEnable_reg;
    reg        charLen9_reg;
    reg        txInvert_reg;
    reg        txEnable_reg;
    reg        sendBreak_reg;
    reg        txEmptyIe_reg;
    reg        txDoneIe_reg;
    reg        rxFullIe_reg;
    reg        txNinth_reg;
    reg        baudSrc_reg;
    reg  [7:0] baudDiv_reg;
    // transmit side
    reg  [7:0] txBuf_reg;
    reg        txBufNinth_reg;
    reg        bufFull_reg;
    reg        txEmpty_reg;
    reg        txDone_reg;
    reg        armTx_reg;
    reg        txState_reg;
    reg [10:0] txShift_reg;
    reg  [3:0] txBitsLeft_reg;
    reg  [3:0] txTick_reg;
    reg  [1:0] txKind_reg;
    reg        preamblePend_reg;
    reg        teLast_reg;
    // receive side
    reg  [1:0] rxState_reg;
    reg  [2:0] rxHist_reg;
    reg  [3:0] rxRt_reg;
    reg  [3:0] rxBitIdx_reg;
    reg  [8:0] rxShift_reg;
    reg  [1:0] rxSamp_reg;
    reg        rxNoiseAcc_reg;
    reg  [7:0] rxData_reg;
    reg        rxNinth_reg;
    reg        rxFull_reg;
    reg        framing_reg;
    reg        noise_reg;
    reg        overrun_reg;
    reg        break_reg;
    reg        armRx_reg;

    wire       tick;
    wire [3:0] frameLen  = charLen9_reg ? `FRAME_LEN_9 : `FRAME_LEN_8;
    wire [3:0] dataBits  = charLen9_reg ? 4'h9 : 4'h8;
    wire       txLastBit = (txState_reg == TX_SHIFT) && (txBitsLeft_reg == 4'h1);
    // no data queued behind the final break means idle follows at once
    wire       shortStop = (txKind_reg == KIND_BREAK) && !sendBreak_reg && !bufFull_reg;
    wire       charEnd   = tick && txLastBit &&
                           ((txTick_reg == `TICKS_LAST) ||
                            (shortStop && txTick_reg == `TICKS_HALF_LAST));
    wire       txSlot    = (txState_reg == TX_IDLE) || charEnd;
    wire       teRise    = txEnable_reg && !teLast_reg;
    wire [2:0] votes     = {rxSamp_reg, serialIn};
    wire       voteBit   = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);
    wire       voteNoise = (votes != 3'b000) && (votes != 3'b111);
    wire       rxDataZero = charLen9_reg ? (rxShift_reg == 9'h000) : (rxShift_reg[7:0] == 8'h00);
    wire       rxBreak   = rxDataZero && !voteBit;
    wire       rxFinish  = tick && (rxState_reg == RX_BITS) && (rxRt_reg == `RT10) &&
                           (rxBitIdx_reg == dataBits);
    wire       sdbWrite  = wrStrobe && (addr == `ADDR_DATA_BUFFER);
    wire       sdbRead   = rdStrobe && (addr == `ADDR_DATA_BUFFER);
    wire       st1Read   = rdStrobe && (addr == `ADDR_STATUS_ONE);
    wire       st2Read   = rdStrobe && (addr == `ADDR_STATUS_TWO);
    reg  [7:0] rdMux;

    // one generator paces both directions
    baud_tick_gen #(
        .ALT_PRESCALE (ALT_PRESCALE)
    ) u_baud (
        .mclk         (mclk),
        .reset        (reset),
        .enable       (moduleEnable_reg),
        .sourceSelect (baudSrc_reg),
        .divisor      (baudDiv_reg),
        .tick         (tick)
    );

    always @* begin
        rdMux = 8'h00;
        case (addr)
            `ADDR_CTRL_ONE: begin
                rdMux[`BIT_MODULE_ENABLE] = moduleEnable_reg;
                rdMux[`BIT_TX_INVERT]     = txInvert_reg;
                rdMux[`BIT_CHAR_LEN9]     = charLen9_reg;
            end
            `ADDR_CTRL_TWO: begin
                rdMux[`BIT_TX_EMPTY_IE] = txEmptyIe_reg;
                rdMux[`BIT_TX_DONE_IE]  = txDoneIe_reg;
                rdMux[`BIT_RX_FULL_IE]  = rxFullIe_reg;
                rdMux[`BIT_TX_ENABLE]   = txEnable_reg;
                rdMux[`BIT_SEND_BREAK]  = sendBreak_reg;
            end
            `ADDR_CTRL_THREE: begin
                rdMux[`BIT_RX_NINTH] = rxNinth_reg;
                rdMux[`BIT_TX_NINTH] = txNinth_reg;
            end
            `ADDR_STATUS_ONE: begin
                rdMux[`BIT_TX_EMPTY] = txEmpty_reg;
                rdMux[`BIT_TX_DONE]  = txDone_reg;
                rdMux[`BIT_RX_FULL]  = rxFull_reg;
                rdMux[`BIT_OVERRUN]  = overrun_reg;
                rdMux[`BIT_NOISE]    = noise_reg;
                rdMux[`BIT_FRAMING]  = framing_reg;
                rdMux[`BIT_PARITY]   = 1'b0;
            end
            `ADDR_STATUS_TWO: begin
                rdMux[`BIT_BREAK]   = break_reg;
                rdMux[`BIT_RX_BUSY] = (rxState_reg != RX_HUNT);
            end
            `ADDR_DATA_BUFFER:  rdMux = rxData_reg;
            `ADDR_BAUD_DIVISOR: rdMux = baudDiv_reg;
            `ADDR_OPTION_TWO:   rdMux[`BIT_BAUD_SOURCE] = baudSrc_reg;
            default:            rdMux = 8'h00;
        endcase
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdData           <= 8'h00;
            serialOut        <= 1'b1;
            serialOutEnN     <= 1'b1;
            txIrq            <= 1'b0;
            rxIrq            <= 1'b0;
            moduleEnable_reg <= 1'b0;
            charLen9_reg     <= 1'b0;
            txInvert_reg     <= 1'b0;
            txEnable_reg     <= 1'b0;
            sendBreak_reg    <= 1'b0;
            txEmptyIe_reg    <= 1'b0;
            txDoneIe_reg     <= 1'b0;
            rxFullIe_reg     <= 1'b0;
            txNinth_reg      <= 1'b0;
            baudSrc_reg      <= 1'b0;
            baudDiv_reg      <= `BAUD_DIVISOR_RESET;
            txBuf_reg        <= 8'h00;
            txBufNinth_reg   <= 1'b0;
            bufFull_reg      <= 1'b0;
            txEmpty_reg      <= 1'b1;
            txDone_reg       <= 1'b1;
            armTx_reg        <= 1'b0;
            txState_reg      <= TX_IDLE;
            txShift_reg      <= 11'h7ff;
            txBitsLeft_reg   <= 4'h0;
            txTick_reg       <= 4'h0;
            txKind_reg       <= KIND_IDLE;
            preamblePend_reg <= 1'b0;
            teLast_reg       <= 1'b0;
            rxState_reg      <= RX_HUNT;
            rxHist_reg       <= 3'b000;
            rxRt_reg         <= 4'h0;
            rxBitIdx_reg     <= 4'h0;
            rxShift_reg      <= 9'h000;
            rxSamp_reg       <= 2'b00;
            rxNoiseAcc_reg   <= 1'b0;
            rxData_reg       <= 8'h00;
            rxNinth_reg      <= 1'b0;
            rxFull_reg       <= 1'b0;
            framing_reg      <= 1'b0;
            noise_reg        <= 1'b0;
            overrun_reg      <= 1'b0;
            break_reg        <= 1'b0;
            armRx_reg        <= 1'b0;
        end else begin
            // register writes
            if (wrStrobe) begin
                case (addr)
                    `ADDR_CTRL_ONE: begin
                        moduleEnable_reg <= wrData[`BIT_MODULE_ENABLE];
                        txInvert_reg     <= wrData[`BIT_TX_INVERT];
                        charLen9_reg     <= wrData[`BIT_CHAR_LEN9];
                    end
                    `ADDR_CTRL_TWO: begin
                        txEmptyIe_reg <= wrData[`BIT_TX_EMPTY_IE];
                        txDoneIe_reg  <= wrData[`BIT_TX_DONE_IE];
                        rxFullIe_reg  <= wrData[`BIT_RX_FULL_IE];
                        txEnable_reg  <= wrData[`BIT_TX_ENABLE];
                        sendBreak_reg <= wrData[`BIT_SEND_BREAK];
                    end
                    `ADDR_CTRL_THREE:   txNinth_reg <= wrData[`BIT_TX_NINTH];
                    `ADDR_BAUD_DIVISOR: baudDiv_reg <= wrData;
                    `ADDR_OPTION_TWO:   baudSrc_reg <= wrData[`BIT_BAUD_SOURCE];
                    default:            ;
                endcase
            end
            rdData <= rdStrobe ? rdMux : 8'h00;

            // transmit buffer handshake; clears first so hardware sets below win
            if (st1Read && txEmpty_reg)
                armTx_reg <= 1'b1;
            if (sdbWrite) begin
                txBuf_reg      <= wrData;
                txBufNinth_reg <= txNinth_reg;
                bufFull_reg    <= 1'b1;
                armTx_reg      <= 1'b0;
                if (armTx_reg)
                    txEmpty_reg <= 1'b0;
            end

            // transmitter
            teLast_reg <= txEnable_reg;
            if (teRise)
                preamblePend_reg <= 1'b1;
            if (teRise && txLastBit && txKind_reg == KIND_DATA && txTick_reg != 4'h0) begin
                bufFull_reg <= 1'b0;
                txEmpty_reg <= 1'b1;
            end
            if (!moduleEnable_reg) begin
                txState_reg      <= TX_IDLE;
                txShift_reg      <= 11'h7ff;
                preamblePend_reg <= 1'b0;
            end else if (txSlot) begin
                txTick_reg <= 4'h0;
                if (!txEnable_reg) begin
                    txState_reg <= TX_IDLE;
                    txShift_reg <= 11'h7ff;
                end else if (sendBreak_reg) begin
                    txState_reg      <= TX_SHIFT;
                    txShift_reg      <= 11'h000;
                    txBitsLeft_reg   <= frameLen;
                    txKind_reg       <= KIND_BREAK;
                    preamblePend_reg <= 1'b1;
                end else if (preamblePend_reg || teRise) begin
                    // a byte buffered while disabled must still wait behind the preamble
                    txState_reg      <= TX_SHIFT;
                    txShift_reg      <= 11'h7ff;
                    txBitsLeft_reg   <= frameLen;
                    txKind_reg       <= KIND_IDLE;
                    preamblePend_reg <= 1'b0;
                end else if (bufFull_reg) begin
                    txState_reg    <= TX_SHIFT;
                    txShift_reg    <= charLen9_reg ? {1'b1, txBufNinth_reg, txBuf_reg, 1'b0}
                                                   : {2'b11, txBuf_reg, 1'b0};
                    txBitsLeft_reg <= frameLen;
                    txKind_reg     <= KIND_DATA;
                    bufFull_reg    <= sdbWrite;
                    txEmpty_reg    <= 1'b1;
                end else begin
                    txState_reg <= TX_IDLE;
                    txShift_reg <= 11'h7ff;
                end
            end else if (tick) begin
                txTick_reg <= txTick_reg + 4'h1;
                if (txTick_reg == `TICKS_LAST) begin
                    txShift_reg    <= {1'b1, txShift_reg[10:1]};
                    txBitsLeft_reg <= txBitsLeft_reg - 4'h1;
                end
            end
            txDone_reg <= (txState_reg == TX_IDLE) && !bufFull_reg &&
                          !preamblePend_reg && !sendBreak_reg;
            serialOut    <= txShift_reg[0] ^ txInvert_reg;
            serialOutEnN <= !moduleEnable_reg;
            txIrq <= (txEmpty_reg && txEmptyIe_reg) || (txDone_reg && txDoneIe_reg);
            rxIrq <= rxFull_reg && rxFullIe_reg;

            // receive flags clear by status-one read then data read; break clears on a status-two read
            if (st1Read && rxFull_reg)
                armRx_reg <= 1'b1;
            if (sdbRead && armRx_reg) begin
                armRx_reg   <= 1'b0;
                rxFull_reg  <= 1'b0;
                framing_reg <= 1'b0;
                noise_reg   <= 1'b0;
                overrun_reg <= 1'b0;
            end
            if (st2Read && break_reg)
                break_reg <= 1'b0;

            // receiver, one step per oversample tick
            if (!moduleEnable_reg) begin
                rxState_reg <= RX_HUNT;
                rxHist_reg  <= 3'b000;
            end else if (tick) begin
                rxRt_reg <= rxRt_reg + 4'h1;
                case (rxState_reg)
                    RX_HUNT: begin
                        rxHist_reg <= {rxHist_reg[1:0], serialIn};
                        if (rxHist_reg == 3'b111 && !serialIn) begin
                            rxState_reg    <= RX_START;
                            rxRt_reg       <= 4'h1;
                            rxNoiseAcc_reg <= 1'b0;
                        end
                    end
                    RX_START: begin
                        if (rxRt_reg == `RT3 || rxRt_reg == `RT5)
                            rxSamp_reg <= {rxSamp_reg[0], serialIn};
                        if (rxRt_reg == `RT7) begin
                            if (voteBit) begin
                                rxState_reg <= RX_HUNT;
                                rxHist_reg  <= 3'b000;
                            end else if (voteNoise) begin
                                rxNoiseAcc_reg <= 1'b1;
                            end
                        end
                        if (rxRt_reg == `TICKS_LAST) begin
                            rxState_reg  <= RX_BITS;
                            rxBitIdx_reg <= 4'h0;
                        end
                    end
                    RX_BITS: begin
                        if (rxRt_reg == `RT8 || rxRt_reg == `RT9)
                            rxSamp_reg <= {rxSamp_reg[0], serialIn};
                        if (rxRt_reg == `RT10) begin
                            if (voteNoise)
                                rxNoiseAcc_reg <= 1'b1;
                            if (rxBitIdx_reg < dataBits)
                                rxShift_reg[rxBitIdx_reg] <= voteBit;
                            rxBitIdx_reg <= rxBitIdx_reg + 4'h1;
                        end
                        if (rxFinish) begin
                            rxState_reg <= RX_HUNT;
                            rxHist_reg  <= {3{voteBit}};
                            rxData_reg  <= rxBreak ? 8'h00 : rxShift_reg[7:0];
                            rxNinth_reg <= rxBreak ? 1'b0 :
                                           (charLen9_reg ? rxShift_reg[8] : rxShift_reg[7]);
                            rxFull_reg  <= 1'b1;
                            framing_reg <= !voteBit;
                            if (rxBreak)
                                break_reg <= 1'b1;
                            if (rxNoiseAcc_reg || voteNoise)
                                noise_reg <= 1'b1;
                            if (rxFull_reg && !(sdbRead && armRx_reg))
                                overrun_reg <= 1'b1;
                        end
                    end
                    default: rxState_reg <= RX_HUNT;
                endcase
            end
        end
    end
endmodule // async_serial_tx_rx_core
`default_nettype wire

// *** hdl/async_serial_defines.vh ***
`ifndef ASYNC_SERIAL_DEFINES_VH
`define ASYNC_SERIAL_DEFINES_VH

`define ADDR_CTRL_ONE      3'h0
`define ADDR_CTRL_TWO      3'h1
`define ADDR_CTRL_THREE    3'h2
`define ADDR_STATUS_ONE    3'h3
`define ADDR_STATUS_TWO    3'h4
`define ADDR_DATA_BUFFER   3'h5
`define ADDR_BAUD_DIVISOR  3'h6
`define ADDR_OPTION_TWO    3'h7

`define BIT_MODULE_ENABLE  6
`define BIT_TX_INVERT      5
`define BIT_CHAR_LEN9      4
`define BIT_TX_EMPTY_IE    7
`define BIT_TX_DONE_IE     6
`define BIT_RX_FULL_IE     5
`define BIT_TX_ENABLE      3
`define BIT_SEND_BREAK     0
`define BIT_RX_NINTH       7
`define BIT_TX_NINTH       6
`define BIT_TX_EMPTY       7
`define BIT_TX_DONE        6
`define BIT_RX_FULL        5
`define BIT_OVERRUN        3
`define BIT_NOISE          2
`define BIT_FRAMING        1
`define BIT_PARITY         0
`define BIT_BREAK          1
`define BIT_RX_BUSY        0
`define BIT_BAUD_SOURCE    0

`define BAUD_DIVISOR_RESET 8'h01
`define TICKS_LAST         4'hf
`define TICKS_HALF_LAST    4'h7
`define RT3                4'h2
`define RT5                4'h4
`define RT7                4'h6
`define RT8                4'h7
`define RT9                4'h8
`define RT10               4'h9
`define FRAME_LEN_8        4'ha
`define FRAME_LEN_9        4'hb

`endif

// *** hdl/baud_tick_gen.v ***
`timescale 1ns/10ps
`default_nettype none
module baud_tick_gen #(
    parameter ALT_PRESCALE = 4
) (
    input  wire       mclk,
    input  wire       reset,
    input  wire       enable,
    input  wire       sourceSelect,
    input  wire [7:0] divisor,
    output reg        tick
);
    reg  [7:0] preCnt_reg;
    reg  [7:0] divCnt_reg;
    wire       srcTick;

    // source 1 runs from a slower prescaled clock enable
    assign srcTick = sourceSelect ? (preCnt_reg == 8'h00) : 1'b1;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            preCnt_reg <= 8'h00;
            divCnt_reg <= 8'h00;
            tick       <= 1'b0;
        end else if (!enable) begin
            preCnt_reg <= 8'h00;
            divCnt_reg <= 8'h00;
            tick       <= 1'b0;
        end else begin
            if (preCnt_reg == ALT_PRESCALE[7:0] - 8'h01)
                preCnt_reg <= 8'h00;
            else
                preCnt_reg <= preCnt_reg + 8'h01;
            tick <= 1'b0;
            if (srcTick) begin
                // divisor 0 is treated as 1
                if (divCnt_reg + 8'h01 >= divisor) begin
                    divCnt_reg <= 8'h00;
                    tick       <= 1'b1;
                end else begin
                    divCnt_reg <= divCnt_reg + 8'h01;
                end
            end
        end
    end
endmodule // baud_tick_gen
`default_nettype wire

// *** dv/async_serial_tx_rx_core_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module async_serial_tx_rx_core_asserts #(
    parameter ALT_PRESCALE = 4
) (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic [2:0] addr,
    input wire logic [7:0] wrData,
    input wire logic       wrStrobe,
    input wire logic       rdStrobe,
    input wire logic [7:0] rdData,
    input wire logic       serialIn,
    input wire logic       serialOut,
    input wire logic       serialOutEnN,
    input wire logic       txIrq,
    input wire logic       rxIrq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    property p_rdIdle; !$past(rdStrobe) |-> rdData == 8'h00; endproperty
    a_rdIdle: assert property (p_rdIdle)
        else $error("read data not zero outside read");
    // half-bit break stop is the shortest legal level
    property p_bitHold; $changed(serialOut) && !serialOutEnN |=> $stable(serialOut)[*7]; endproperty
    a_bitHold: assert property (p_bitHold)
        else $error("serial level held too short");
    property p_enOff; wrStrobe && addr == 3'h0 && !wrData[6] |-> ##[1:2] serialOutEnN; endproperty
    a_enOff: assert property (p_enOff)
        else $error("pin not released");
    property p_enOn; wrStrobe && addr == 3'h0 && wrData[6] |-> ##[1:2] !serialOutEnN; endproperty
    a_enOn: assert property (p_enOn)
        else $error("pin not driven");
    property p_txIrqOff; wrStrobe && addr == 3'h1 && wrData[7:6] == 2'b00 |-> ##[1:2] !txIrq; endproperty
    a_txIrqOff: assert property (p_txIrqOff)
        else $error("tx request without enable");
    property p_rxIrqOff; wrStrobe && addr == 3'h1 && !wrData[5] |-> ##[1:2] !rxIrq; endproperty
    a_rxIrqOff: assert property (p_rxIrqOff)
        else $error("rx request without enable");
    property p_st1Rsv; rdStrobe && addr == 3'h3 |=> rdData[4] == 1'b0 && rdData[0] == 1'b0; endproperty
    a_st1Rsv: assert property (p_st1Rsv)
        else $error("status one spare bits set");
    property p_st2Rsv; rdStrobe && addr == 3'h4 |=> rdData[7:2] == 6'h00; endproperty
    a_st2Rsv: assert property (p_st2Rsv)
        else $error("status two spare bits set");
    c_rx: cover property ($rose(rxIrq));
    c_tx: cover property ($rose(txIrq));
    c_start: cover property ($fell(serialOut) && !serialOutEnN);
endmodule // async_serial_tx_rx_core_asserts
`default_nettype wire

// *** dv/serial_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
module serial_partner (
    input  wire logic       mclk,
    input  wire logic       line,
    input  wire logic       lineEnN,
    output logic            serialIn,
    output logic [7:0]      lastRx,
    output logic            stopOk,
    output var int          rxCount
);
    initial begin
        serialIn = 1'b1;
        lastRx = 8'h00;
        stopOk = 1'b0;
        rxCount = 0;
    end
    // divisor 1: one bit is 16 mclk; noisy flips the middle sample of data bit 0
    task automatic send(input logic [8:0] b, input logic brk, input logic nine,
                        input logic noisy);
        int last;
        last = nine ? 10 : 9;
        for (int i = 0; i <= last; i++) begin
            @(posedge mclk);
            serialIn <= (i == 0) ? 1'b0 : (i == last) ? ~brk : b[i-1];
            if (noisy && i == 1) begin
                repeat (8) @(posedge mclk);
                serialIn <= ~b[0];
                @(posedge mclk);
                serialIn <= b[0];
                repeat (6) @(posedge mclk);
            end else begin
                repeat (15) @(posedge mclk);
            end
        end
        @(posedge mclk);
        serialIn <= 1'b1;
        // gap so the hunt sees three ones
        repeat (47) @(posedge mclk);
    endtask
    // decoder trusts start edges only while the pin is driven
    always begin
        @(negedge line iff (lineEnN == 1'b0));
        repeat (24) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            lastRx[i] = line;
            repeat (16) @(posedge mclk);
        end
        stopOk = line;
        rxCount++;
    end
endmodule // serial_partner
`default_nettype wire

// *** dv/async_serial_tx_rx_core_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module async_serial_tx_rx_core_tb;
    logic       mclk, reset, wrStrobe, rdStrobe, serialIn, serialOut, serialOutEnN, txIrq, rxIrq;
    logic       stopOk;
    logic [2:0] addr;
    logic [7:0] wrData, rdData, lastRx, d, b;
    int         rxCount, errors, comparisons, n;
    async_serial_tx_rx_core #(.ALT_PRESCALE(4)) async_serial_tx_rx_core_inst (.mclk(mclk),
        .reset(reset), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .rdData(rdData), .serialIn(serialIn), .serialOut(serialOut),
        .serialOutEnN(serialOutEnN), .txIrq(txIrq), .rxIrq(rxIrq));
    serial_partner serial_partner_inst (.mclk(mclk), .line(serialOut), .lineEnN(serialOutEnN),
        .serialIn(serialIn), .lastRx(lastRx), .stopOk(stopOk), .rxCount(rxCount));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    function automatic logic [7:0] rxStatus(input logic brk);
        return 8'he0 | {6'h00, brk, 1'b0};
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        wrStrobe <= 1'b1; addr <= a; wrData <= v;
        @(posedge mclk);
        wrStrobe <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        rdStrobe <= 1'b1; addr <= a;
        @(posedge mclk);
        rdStrobe <= 1'b0;
        #1 v = rdData;
    endtask
    task automatic close_out;
        if (errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        close_out();
    end
    initial begin
        reset = 1'b1; addr = 3'h0; wrData = 8'h00; wrStrobe = 1'b0; rdStrobe = 1'b0;
        errors = 0; comparisons = 0;
        void'($urandom(12));
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        check("idle", {7'h00, serialOut}, 8'h01);
        check("release", {7'h00, serialOutEnN}, 8'h01);
        wr(3'h0, 8'h40);
        wr(3'h1, 8'h28);
        for (int i = 0; i < 5; i++) begin
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom());
            rd(3'h3, d);
            check("tx empty", d & 8'h80, 8'h80);
            n = rxCount;
            wr(3'h5, b);
            // first character waits behind the preamble
            for (int k = 0; k < 700 && rxCount == n; k++) @(posedge mclk);
            check("tx byte", lastRx, b);
            check("tx stop", {7'h00, stopOk}, 8'h01);
            serial_partner_inst.send({1'b0, b}, 1'b0, 1'b0, 1'b0);
            check("rx irq", {7'h00, rxIrq}, 8'h01);
            rd(3'h3, d);
            check("rx status", d, rxStatus(1'b0));
            rd(3'h2, d);
            check("ninth copy", d & 8'h80, b & 8'h80);
            rd(3'h5, d);
            check("rx byte", d, b);
        end
        // slow source: nine low bits last 576 clocks instead of 144
        wr(3'h7, 8'h01);
        rd(3'h3, d);
        wr(3'h5, 8'h00);
        repeat (300) @(posedge mclk);
        check("slow source", {7'h00, serialOut}, 8'h00);
        repeat (400) @(posedge mclk);
        wr(3'h7, 8'h00);
        // tx_enable toggled mid-character slots one idle before the next byte
        b = 8'($urandom());
        rd(3'h3, d);
        n = rxCount;
        wr(3'h5, b);
        repeat (40) @(posedge mclk);
        wr(3'h1, 8'h20);
        wr(3'h1, 8'h28);
        rd(3'h3, d);
        wr(3'h5, 8'h00);
        for (int k = 0; k < 400 && rxCount == n; k++) @(posedge mclk);
        check("toggle byte", lastRx, b);
        repeat (100) @(posedge mclk);
        check("queued idle", {7'h00, serialOut}, 8'h01);
        n = rxCount;
        for (int k = 0; k < 400 && rxCount == n; k++) @(posedge mclk);
        check("after idle", lastRx, 8'h00);
        rd(3'h3, d);
        n = rxCount;
        wr(3'h5, b);
        repeat (40) @(posedge mclk);
        wr(3'h1, 8'h20);
        for (int k = 0; k < 400 && rxCount == n; k++) @(posedge mclk);
        check("te off byte", lastRx, b);
        check("te off stop", {7'h00, stopOk}, 8'h01);
        repeat (20) @(posedge mclk);
        // no byte queued behind the last break halves its stop-position zero
        wr(3'h1, 8'h29);
        wr(3'h1, 8'h28);
        n = 0;
        repeat (200) begin
            @(posedge mclk);
            n += !serialOut;
        end
        check("break low", 8'(n), 8'(9 * 16 + 8));
        serial_partner_inst.send(9'h000, 1'b1, 1'b0, 1'b0);
        rd(3'h3, d);
        check("brk status", d, rxStatus(1'b1));
        rd(3'h5, d);
        check("brk data", d, 8'h00);
        rd(3'h2, d);
        check("brk ninth", d & 8'h80, 8'h00);
        rd(3'h4, d);
        check("brk flag", d, 8'h02);
        wr(3'h0, 8'h50);
        b = 8'($urandom());
        wr(3'h2, {1'b0, b[0], 6'h00});
        rd(3'h3, d);
        n = rxCount;
        wr(3'h5, b);
        for (int k = 0; k < 400 && rxCount == n; k++) @(posedge mclk);
        // the decoder reads eight bits, so its stop sample lands on the ninth bit
        check("tx9 byte", lastRx, b);
        check("tx9 ninth", {7'h00, stopOk}, {7'h00, b[0]});
        serial_partner_inst.send({~b[7], b}, 1'b0, 1'b1, 1'b1);
        serial_partner_inst.send({b[7], ~b}, 1'b0, 1'b1, 1'b0);
        rd(3'h3, d);
        check("rx9 status", d, rxStatus(1'b0) | 8'h0c);
        rd(3'h2, d);
        check("rx9 ninth", d & 8'h80, {b[7], 7'h00});
        rd(3'h5, d);
        check("rx9 byte", d, ~b);
        for (int i = 0; i < 2; i++) begin
            wr(3'h1, i ? 8'h48 : 8'h88);
            repeat (2) @(posedge mclk);
            check("tx irq", {7'h00, txIrq}, 8'h01);
        end
        wr(3'h0, 8'h60);
        // long wait keeps the inverted level stable before disable
        repeat (12) @(posedge mclk);
        check("inverted idle", {7'h00, serialOut}, 8'h00);
        wr(3'h0, 8'h00);
        repeat (3) @(posedge mclk);
        check("disabled", {7'h00, serialOutEnN}, 8'h01);
        close_out();
    end
endmodule // async_serial_tx_rx_core_tb
bind async_serial_tx_rx_core async_serial_tx_rx_core_asserts #(.ALT_PRESCALE(ALT_PRESCALE))
    async_serial_tx_rx_core_asserts_inst (.mclk(mclk), .reset(reset), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
    .txIrq(txIrq), .rxIrq(rxIrq));
`default_nettype wire
